/* File: core/mgmt_regs_pkg.sv */
// Package of register offsets, fields, reset values and sizes for the block.
`default_nettype none
package mgmt_regs_pkg;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int NUM_PORTS = 8;
    localparam logic [2:0] ADDR_INDEX_LO = 3'h0;
    localparam logic [2:0] ADDR_INDEX_HI = 3'h1;
    localparam logic [2:0] ADDR_DATA_WIN = 3'h2;
    localparam logic [2:0] ADDR_CMD_STATUS = 3'h4;
    localparam logic [2:0] ADDR_INT_SRC = 3'h5;
    localparam logic [2:0] ADDR_BUF_ONE = 3'h6;
    localparam logic [2:0] ADDR_BUF_TWO = 3'h7;
    localparam logic [15:0] PORT_CTL_BASE = 16'h0000;
    localparam logic [15:0] I2C_PORT_CTL_BASE = 16'h0000;
    localparam int INT_CPU_FRAME = 0;
    localparam int INT_BUF_ONE = 1;
    localparam int INT_BUF_TWO = 2;
    localparam int INT_TIMEOUT = 7;
    localparam logic [7:0] INT_USED_MASK = 8'h87;
    localparam int CMD_RX_READY = 0;
    localparam int CMD_TX1_DONE = 1;
    localparam int CMD_TX2_DONE = 2;
    localparam int PC_FC_OFF = 0;
    localparam int PC_HALF = 1;
    localparam int PC_SPEED10 = 2;
    localparam int PC_AN_LO = 3;
    localparam int PC_ASYM = 5;
    localparam int PC_STP_LO = 6;
    localparam logic [7:0] PORT_CTL_RESET = 8'hC0;
    localparam logic [1:0] AN_AUTO = 2'h0;
    localparam logic [1:0] AN_LIMITED = 2'h1;
    localparam logic [1:0] AN_FORCE_DOWN = 2'h2;
    localparam logic [1:0] AN_FORCE_UP = 2'h3;
    localparam logic [1:0] STP_LEARNING = 2'h2;
    localparam logic [1:0] STP_FORWARDING = 2'h3;
    localparam logic [15:0] PAUSE_CNT_RESET = 16'h0000;
endpackage
`default_nettype wire

/* File: core/cmd_fifo.sv */
// Parameterised flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module cmd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // --------------------------------------------------------------
    // Handshake
    // --------------------------------------------------------------
    // Full and empty come straight from the occupancy count.
    assign in_ready = cnt_q < (AW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign push = in_valid && in_ready && clk_en;
    assign pop = out_valid && out_ready && clk_en;
    assign out_data = mem_q[rd_q];
    assign level = cnt_q;

    // Storage writes.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and count.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: core/mgmt_regs.sv */
// Management register logic: interrupt sources, command buffers, port control.
`timescale 1ns/1ps
`default_nettype none
module mgmt_regs (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic bus_16bit,
    input wire logic [2:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [15:0] cpu_wdata,
    output logic [15:0] cpu_rdata,
    output logic cpu_irq,
    input wire logic i2c_wr,
    input wire logic [7:0] i2c_addr,
    input wire logic [7:0] i2c_wdata,
    output logic [7:0] i2c_rdata,
    input wire logic cpu_frame_event,
    input wire logic timeout_event,
    output logic [15:0] cmd_in_data,
    output logic cmd_in_valid,
    input wire logic cmd_in_ready,
    output logic cmd_in_frame_ready,
    input wire logic [15:0] out1_data,
    input wire logic out1_valid,
    output logic out1_ready,
    output logic out1_released,
    input wire logic [15:0] out2_data,
    input wire logic out2_valid,
    output logic out2_ready,
    output logic out2_released,
    input wire logic [7:0] pause_rx,
    input wire logic [7:0] pause_need,
    input wire logic [7:0] congest,
    output logic [7:0] send_pause,
    output logic [7:0] obey_pause,
    output logic [7:0] back_pressure,
    output logic [7:0] half_duplex,
    output logic [7:0] speed_10,
    output logic [7:0] link_forced_down,
    output logic [7:0] link_forced_up,
    output logic [7:0] phy_poll_en,
    output logic [7:0] autoneg_en,
    output logic [7:0] frame_forward,
    output logic [7:0] addr_learn,
    output logic [15:0] pause_count [8]
);
    logic [7:0] int_q;
    logic [7:0] int_d;
    logic [15:0] index_q;
    logic [7:0] port_ctl_q [8];
    logic [15:0] rdata_q;
    logic out1_seen_q;
    logic out2_seen_q;
    logic [15:0] pause_cnt_q [8];
    logic [15:0] bus_mask;
    logic [15:0] fifo_out;
    logic [4:0] fifo_level;
    logic wr_buf1;
    logic wr_data_win;
    logic rd_buf1;
    logic rd_buf2;
    logic cmd_wr;
    logic idx_hit;
    logic [2:0] idx_port;

    // Assertions sample on the system clock and rest while reset is high.
    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    // Mask that keeps only the active lanes of the CPU bus.
    function automatic logic [15:0] lane_mask(input logic wide);
        lane_mask = wide ? 16'hFFFF : 16'h00FF;
    endfunction

    // Decode an indirect address into a port control hit and port number.
    function automatic logic [3:0] port_decode(input logic [15:0] a);
        logic [15:0] off;
        off = a - mgmt_regs_pkg::PORT_CTL_BASE;
        port_decode = {(off[0] == 1'b0) && (off[15:4] == 12'h000), off[3:1]};
    endfunction

    // --------------------------------------------------------------
    // Bus decode
    // --------------------------------------------------------------
    // Strobes are qualified by the clock enable so all state freezes.
    assign bus_mask = lane_mask(bus_16bit);
    assign wr_buf1 = clk_en && cpu_wr
        && cpu_addr == mgmt_regs_pkg::ADDR_BUF_ONE;
    assign wr_data_win = clk_en && cpu_wr
        && cpu_addr == mgmt_regs_pkg::ADDR_DATA_WIN;
    assign rd_buf1 = clk_en && cpu_rd
        && cpu_addr == mgmt_regs_pkg::ADDR_BUF_ONE;
    assign rd_buf2 = clk_en && cpu_rd
        && cpu_addr == mgmt_regs_pkg::ADDR_BUF_TWO;
    assign cmd_wr = clk_en && cpu_wr
        && cpu_addr == mgmt_regs_pkg::ADDR_CMD_STATUS;
    assign {idx_hit, idx_port} = port_decode(index_q);
    assign out1_ready = rd_buf1 && out1_valid;
    assign out2_ready = rd_buf2 && out2_valid;

    // --------------------------------------------------------------
    // Inbound command buffer
    // --------------------------------------------------------------
    // Writes to address 6 enter the FIFO; a full FIFO drops the word.
    cmd_fifo #(
        .WIDTH(mgmt_regs_pkg::DATA_W),
        .DEPTH(mgmt_regs_pkg::FIFO_DEPTH)
    ) u_cmd_fifo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_data(cpu_wdata & bus_mask),
        .in_valid(wr_buf1),
        .in_ready(),
        .out_data(fifo_out),
        .out_valid(cmd_in_valid),
        .out_ready(cmd_in_ready),
        .level(fifo_level)
    );
    assign cmd_in_data = fifo_out;

    // Command register strobes: frame ready and buffer released pulses.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cmd_in_frame_ready <= 1'b0;
            out1_released <= 1'b0;
            out2_released <= 1'b0;
        end else if (clk_en) begin
            cmd_in_frame_ready <= cmd_wr
                && cpu_wdata[mgmt_regs_pkg::CMD_RX_READY];
            out1_released <= cmd_wr && cpu_wdata[mgmt_regs_pkg::CMD_TX1_DONE];
            out2_released <= cmd_wr && cpu_wdata[mgmt_regs_pkg::CMD_TX2_DONE];
        end
    end

    // Index register, low half at address 0, high half at 1 in 8-bit mode.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            index_q <= 16'h0000;
        end else if (clk_en && cpu_wr) begin
            if (cpu_addr == mgmt_regs_pkg::ADDR_INDEX_LO) begin
                index_q <= bus_16bit ? cpu_wdata
                    : {index_q[15:8], cpu_wdata[7:0]};
            end else if (cpu_addr == mgmt_regs_pkg::ADDR_INDEX_HI
                    && !bus_16bit) begin
                index_q[15:8] <= cpu_wdata[7:0];
            end
        end
    end

    // --------------------------------------------------------------
    // Interrupt sources
    // --------------------------------------------------------------
    // Track whether each outbound buffer has been read since its release.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            out1_seen_q <= 1'b0;
            out2_seen_q <= 1'b0;
        end else if (clk_en) begin
            out1_seen_q <= out1_released ? 1'b0 : (out1_seen_q || out1_ready);
            out2_seen_q <= out2_released ? 1'b0 : (out2_seen_q || out2_ready);
        end
    end

    // Next interrupt value; a set always wins over a clear.
    always_comb begin
        int_d = int_q;
        if (clk_en && cpu_wr && cpu_addr == mgmt_regs_pkg::ADDR_INT_SRC) begin
            int_d = int_q & cpu_wdata[7:0];
        end
        if (out1_released && !out1_valid) begin
            int_d[mgmt_regs_pkg::INT_BUF_ONE] = 1'b0;
        end
        if (out2_released && !out2_valid) begin
            int_d[mgmt_regs_pkg::INT_BUF_TWO] = 1'b0;
        end
        if (cpu_frame_event) begin
            int_d[mgmt_regs_pkg::INT_CPU_FRAME] = 1'b1;
        end
        if (out1_valid && !out1_seen_q) begin
            int_d[mgmt_regs_pkg::INT_BUF_ONE] = 1'b1;
        end
        if (out2_valid && !out2_seen_q) begin
            int_d[mgmt_regs_pkg::INT_BUF_TWO] = 1'b1;
        end
        if (timeout_event) begin
            int_d[mgmt_regs_pkg::INT_TIMEOUT] = 1'b1;
        end
        int_d = int_d & mgmt_regs_pkg::INT_USED_MASK;
    end

    // Interrupt register storage.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            int_q <= 8'h00;
        end else if (clk_en) begin
            int_q <= int_d;
        end
    end

    // The interrupt line follows any unreserved source bit.
    assign cpu_irq = |(int_q & mgmt_regs_pkg::INT_USED_MASK);

    // --------------------------------------------------------------
    // Port control registers
    // --------------------------------------------------------------
    // CPU writes through the data window, I2C writes directly.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < mgmt_regs_pkg::NUM_PORTS; i++) begin
                port_ctl_q[i] <= mgmt_regs_pkg::PORT_CTL_RESET;
            end
        end else if (clk_en) begin
            if (wr_data_win && idx_hit) begin
                port_ctl_q[idx_port] <= cpu_wdata[7:0];
            end
            if (i2c_wr && i2c_addr[7:3]
                    == mgmt_regs_pkg::I2C_PORT_CTL_BASE[7:3]) begin
                port_ctl_q[i2c_addr[2:0]] <= i2c_wdata;
            end
        end
    end

    // I2C read path.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            i2c_rdata <= 8'h00;
        end else if (clk_en) begin
            i2c_rdata <= port_ctl_q[i2c_addr[2:0]];
        end
    end

    // Decode each port's control fields into MAC behaviour.
    always_comb begin
        for (int i = 0; i < mgmt_regs_pkg::NUM_PORTS; i++) begin
            logic fc_on;
            logic [1:0] an;
            logic [1:0] stp;
            fc_on = !port_ctl_q[i][mgmt_regs_pkg::PC_FC_OFF];
            an = port_ctl_q[i][mgmt_regs_pkg::PC_AN_LO +: 2];
            stp = port_ctl_q[i][mgmt_regs_pkg::PC_STP_LO +: 2];
            speed_10[i] = port_ctl_q[i][mgmt_regs_pkg::PC_SPEED10];
            half_duplex[i] = port_ctl_q[i][mgmt_regs_pkg::PC_HALF];
            autoneg_en[i] = an == mgmt_regs_pkg::AN_AUTO;
            phy_poll_en[i] = an == mgmt_regs_pkg::AN_AUTO
                || an == mgmt_regs_pkg::AN_LIMITED;
            link_forced_down[i] = an == mgmt_regs_pkg::AN_FORCE_DOWN;
            link_forced_up[i] = an == mgmt_regs_pkg::AN_FORCE_UP;
            back_pressure[i] = fc_on && half_duplex[i] && congest[i]
                && !link_forced_down[i];
            send_pause[i] = fc_on && !half_duplex[i] && pause_need[i]
                && !port_ctl_q[i][mgmt_regs_pkg::PC_ASYM]
                && !link_forced_down[i];
            obey_pause[i] = fc_on && !half_duplex[i];
            frame_forward[i] = stp == mgmt_regs_pkg::STP_FORWARDING;
            addr_learn[i] = stp == mgmt_regs_pkg::STP_FORWARDING
                || stp == mgmt_regs_pkg::STP_LEARNING;
        end
    end

    // Received pause counters advance only while pauses are obeyed.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < mgmt_regs_pkg::NUM_PORTS; i++) begin
                pause_cnt_q[i] <= mgmt_regs_pkg::PAUSE_CNT_RESET;
            end
        end else if (clk_en) begin
            for (int i = 0; i < mgmt_regs_pkg::NUM_PORTS; i++) begin
                if (pause_rx[i] && obey_pause[i]) begin
                    pause_cnt_q[i] <= pause_cnt_q[i] + 16'h0001;
                end
            end
        end
    end
    assign pause_count = pause_cnt_q;

    // --------------------------------------------------------------
    // Read data
    // --------------------------------------------------------------
    // Read data is registered and lands one cycle after the strobe.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_q <= 16'h0000;
        end else if (clk_en && cpu_rd) begin
            case (cpu_addr)
                mgmt_regs_pkg::ADDR_INT_SRC: begin
                    rdata_q <= {8'h00, int_q};
                end
                mgmt_regs_pkg::ADDR_DATA_WIN: begin
                    rdata_q <= idx_hit ? {8'h00, port_ctl_q[idx_port]}
                        : 16'h0000;
                end
                mgmt_regs_pkg::ADDR_BUF_ONE: begin
                    rdata_q <= out1_valid ? out1_data & bus_mask : 16'h0000;
                end
                mgmt_regs_pkg::ADDR_BUF_TWO: begin
                    rdata_q <= out2_valid ? out2_data & bus_mask : 16'h0000;
                end
                mgmt_regs_pkg::ADDR_CMD_STATUS: begin
                    rdata_q <= {13'h0000, out2_valid, out1_valid,
                        fifo_level != 5'(mgmt_regs_pkg::FIFO_DEPTH)};
                end
                default: begin
                    rdata_q <= 16'h0000;
                end
            endcase
        end
    end
    assign cpu_rdata = rdata_q;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    chk_timeout_sticks: assert property (
        clk_en && timeout_event |=> int_q[7])
        else $error("timeout bit not set");
    chk_timeout_hold: assert property (
        int_q[7] && !(cpu_wr && cpu_addr == 3'h5) |=> int_q[7])
        else $error("timeout bit lost");
    chk_reserved_zero: assert property (
        int_q[6:3] == 4'h0)
        else $error("reserved interrupt bits set");
    chk_irq_follows: assert property (
        cpu_irq == (int_q[0] || int_q[1] || int_q[2] || int_q[7]))
        else $error("irq mismatch");
    chk_buf1_flag: assert property (
        clk_en && out1_valid && !out1_seen_q |=> int_q[1])
        else $error("buffer one flag missing");
    chk_pause_off: assert property (
        port_ctl_q[0][0] |=> $stable(pause_cnt_q[0]))
        else $error("pause counted while off");
    chk_asym_pause: assert property (
        port_ctl_q[0][5] |-> !send_pause[0])
        else $error("pause sent in asymmetric mode");
    chk_read_lat: assert property (
        rd_buf2 && out2_valid && bus_16bit |=> cpu_rdata == $past(out2_data))
        else $error("buffer two read data wrong");
    cov_timeout: cover property (@(posedge sys_clk) timeout_event ##1 int_q[7]);
    cov_buf_push: cover property (@(posedge sys_clk) wr_buf1 ##1 cmd_in_valid);
    cov_port_write: cover property (@(posedge sys_clk) wr_data_win && idx_hit);
endmodule
`default_nettype wire

/* File: tb/cpu_host.sv */
// Host processor model that drives the management bus of the block.
`timescale 1ns/1ps
`default_nettype none
module cpu_host (
    input wire logic sys_clk,
    output logic [2:0] cpu_addr,
    output logic cpu_wr,
    output logic cpu_rd,
    output logic [15:0] cpu_wdata,
    input wire logic [15:0] cpu_rdata
);
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // The bus starts idle, with no strobe raised.
    initial begin
        cpu_addr = 3'h0;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        cpu_wdata = 16'h0000;
    end

    // One-cycle write; the released data bus shows the inverse word.
    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        #1;
        cpu_addr = a;
        cpu_wdata = v;
        cpu_wr = 1'b1;
        @(posedge sys_clk);
        #1;
        cpu_wr = 1'b0;
        cpu_wdata = ~v;
    endtask

    // One-cycle read; the word is registered one cycle later.
    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        #1;
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(posedge sys_clk);
        #1;
        cpu_rd = 1'b0;
        v = cpu_rdata;
    endtask

    // Indirect access loads the index first, then uses the window.
    task automatic ind_wr(input logic [15:0] ix, input logic [7:0] v);
        wr(mgmt_regs_pkg::ADDR_INDEX_LO, ix);
        wr(mgmt_regs_pkg::ADDR_DATA_WIN, {8'h00, v});
    endtask

    task automatic ind_rd(input logic [15:0] ix, output logic [15:0] v);
        wr(mgmt_regs_pkg::ADDR_INDEX_LO, ix);
        rd(mgmt_regs_pkg::ADDR_DATA_WIN, v);
    endtask

    // Frame handshakes go through the command register.
    task automatic frame_done(input logic [7:0] bits);
        wr(mgmt_regs_pkg::ADDR_CMD_STATUS, {8'h00, bits});
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_mgmt_regs.sv */
// Self-checking bench for the management register block.
`timescale 1ns/1ps
`default_nettype none
module tb_mgmt_regs;
    logic sys_clk, sys_rst, bus_16bit, cpu_wr, cpu_rd, i2c_wr, cpu_irq;
    logic cpu_frame_event, timeout_event, cmd_in_ready, cmd_in_valid;
    logic out1_valid, out2_valid;
    logic [2:0] cpu_addr;
    logic [7:0] i2c_addr, i2c_wdata, i2c_rdata, pause_rx, pause_need;
    logic [7:0] congest, send_pause, obey_pause, back_pressure, half_duplex;
    logic [7:0] speed_10, link_forced_down, link_forced_up, phy_poll_en;
    logic [7:0] autoneg_en, frame_forward, addr_learn;
    logic [15:0] cpu_wdata, cpu_rdata, cmd_in_data, out1_data, out2_data, d;
    logic [15:0] pause_count [8];
    wire [4:0] strb;
    logic [4:0] seen;
    int errors = 0;
    int cmp_count = 0;

    // ------------------------------------------------------------
    // Design, host model, clock and watchdog
    // ------------------------------------------------------------
    mgmt_regs mgmt_regs_i (.sys_clk, .sys_rst, .clk_en(1'b1), .bus_16bit,
        .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .cpu_irq,
        .i2c_wr, .i2c_addr, .i2c_wdata, .i2c_rdata, .cpu_frame_event,
        .timeout_event, .cmd_in_data, .cmd_in_valid, .cmd_in_ready,
        .cmd_in_frame_ready(strb[0]), .out1_data, .out1_valid,
        .out1_ready(strb[1]), .out1_released(strb[2]), .out2_data,
        .out2_valid, .out2_ready(strb[3]), .out2_released(strb[4]),
        .pause_rx, .pause_need, .congest, .send_pause,
        .obey_pause, .back_pressure, .half_duplex, .speed_10,
        .link_forced_down, .link_forced_up, .phy_poll_en, .autoneg_en,
        .frame_forward, .addr_learn, .pause_count);
    cpu_host cpu_host_i (.sys_clk, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata,
        .cpu_rdata);

    // The clock toggles every half period of 4 ns.
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // A hang is cut short long after the sequence should have ended.
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        tally_and_finish;
    end

    // Remembers every strobe pulse that the block has raised since reset.
    always @(posedge sys_clk) begin
        seen <= sys_rst ? 5'h00 : seen | strb;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Lets one edge pass, then steps just past it.
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask

    // Compares one result word and counts it.
    task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Port control comes up as flow on, full, 100M, autoneg, forwarding.
    task automatic t_reset;
        cpu_host_i.ind_rd(16'h0006, d);
        chk_w(d, 16'h00C0);
        chk_w({frame_forward, autoneg_en}, 16'hFFFF);
        chk_w({half_duplex, speed_10}, 16'h0000);
    endtask

    // Every negotiation and tree state code, written by CPU and read back by serial port; one serial write read by CPU.
    task automatic t_port;
        logic [3:0] an [4] = '{4'hC, 4'h4, 4'h2, 4'h1};
        logic [1:0] stp [4] = '{2'h0, 2'h0, 2'h1, 2'h3};
        logic [1:0] sd;
        logic [15:0] g, e;
        for (int i = 0; i < 4; i++) begin
            sd = i[0] ? i[1:0] : 2'h0;
            e = {8'h00, i[1:0], 1'b0, i[1:0], sd, 1'b0};
            cpu_host_i.ind_wr(16'h000A, e[7:0]);
            i2c_addr = 8'h05;
            tick;
            tick;
            chk_w({8'h00, i2c_rdata}, e);
            g = {8'h00, autoneg_en[5], phy_poll_en[5], link_forced_down[5],
                link_forced_up[5], frame_forward[5], addr_learn[5],
                speed_10[5], half_duplex[5]};
            e = {8'h00, an[i], stp[i], sd};
            chk_w(g, e);
        end
        {i2c_addr, i2c_wdata, i2c_wr} = {8'h06, 8'h3D, 1'b1};
        tick;
        i2c_wr = 1'b0;
        cpu_host_i.ind_rd(16'h000C, d);
        chk_w(d, 16'h003D);
    endtask

    // Flow control table: {count step, back pressure, obey, send}.
    task automatic t_flow;
        logic [7:0] ctl [5] = '{8'hC0, 8'hC2, 8'hC1, 8'hC3, 8'hE0};
        logic [3:0] ex [5] = '{4'hB, 4'h4, 4'h0, 4'h0, 4'hA};
        logic [3:0] mk [5] = '{4'hF, 4'h4, 4'hF, 4'h5, 4'hF};
        logic [15:0] c0, g, e;
        for (int i = 0; i < 5; i++) begin
            cpu_host_i.ind_wr(16'h0000, ctl[i]);
            c0 = pause_count[0];
            pause_rx = 8'h01;
            tick;
            pause_rx = 8'h00;
            tick;
            g = {12'h000, mk[i] & {pause_count[0] != c0, back_pressure[0],
                obey_pause[0], send_pause[0]}};
            e = {12'h000, mk[i] & ex[i]};
            chk_w(g, e);
        end
    endtask

    // Timeout sticks across reads until written to zero.
    task automatic t_irq;
        {cpu_frame_event, timeout_event} = 2'h3;
        tick;
        {cpu_frame_event, timeout_event} = 2'h0;
        tick;
        chk_w({15'h0000, cpu_irq}, 16'h0001);
        repeat (2) begin
            cpu_host_i.rd(mgmt_regs_pkg::ADDR_INT_SRC, d);
            chk_w(d, 16'h0081);
        end
        cpu_host_i.wr(mgmt_regs_pkg::ADDR_INT_SRC, 16'h007F);
        cpu_host_i.rd(mgmt_regs_pkg::ADDR_INT_SRC, d);
        chk_w(d, 16'h0001);
        cpu_host_i.wr(mgmt_regs_pkg::ADDR_INT_SRC, 16'h0000);
        tick;
        chk_w({15'h0000, cpu_irq}, 16'h0000);
    endtask

    // Fill the inbound buffer past full while stalled, then drain it.
    task automatic t_fifo;
        for (int k = 0; k < 17; k++) begin
            cpu_host_i.wr(mgmt_regs_pkg::ADDR_BUF_ONE, 16'hA000 + k[15:0]);
        end
        for (int k = 0; k < 16; k++) begin
            chk_w({cmd_in_valid, cmd_in_data[14:0]}, 16'hA000 + k[15:0]);
            cmd_in_ready = 1'b1;
            tick;
            cmd_in_ready = 1'b0;
        end
        chk_w({15'h0000, cmd_in_valid}, 16'h0000);
        bus_16bit = 1'b0;
        cpu_host_i.wr(mgmt_regs_pkg::ADDR_BUF_ONE, 16'h5A3C);
        tick;
        chk_w(cmd_in_data, 16'h003C);
        cmd_in_ready = 1'b1;
        tick;
        {cmd_in_ready, bus_16bit} = 2'h1;
        cpu_host_i.frame_done(8'h01);
    endtask

    // An outbound word raises its flag, is read, then released.
    task automatic t_out(input logic two);
        {out1_valid, out2_valid} = {~two, two};
        {out1_data, out2_data} = {16'h1357, 16'h2468};
        tick;
        tick;
        cpu_host_i.rd(mgmt_regs_pkg::ADDR_INT_SRC, d);
        chk_w(d, two ? 16'h0004 : 16'h0002);
        cpu_host_i.rd(two ? mgmt_regs_pkg::ADDR_BUF_TWO :
            mgmt_regs_pkg::ADDR_BUF_ONE, d);
        {out1_valid, out2_valid} = 2'h0;
        chk_w(d, two ? 16'h2468 : 16'h1357);
        cpu_host_i.frame_done(two ? 8'h04 : 8'h02);
        cpu_host_i.rd(mgmt_regs_pkg::ADDR_INT_SRC, d);
        chk_w(d, 16'h0000);
        chk_w({11'h000, seen}, two ? 16'h001F : 16'h0007);
    endtask

    // Inputs settle at time zero, reset holds 16 cycles, then the tests.
    initial begin
        {sys_rst, bus_16bit, i2c_wr, cpu_frame_event} = 4'hC;
        {timeout_event, cmd_in_ready, out1_valid, out2_valid} = 4'h0;
        {i2c_addr, i2c_wdata, pause_rx} = 24'h000000;
        {pause_need, congest} = 16'hFFFF;
        {out1_data, out2_data} = 32'h00000000;
        repeat (16) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_port();
        t_flow();
        t_irq();
        t_fifo();
        t_out(1'b0);
        t_out(1'b1);
        tally_and_finish;
    end
endmodule
`default_nettype wire
